// ==== hdl/black_level_ctrl.sv ====
// Black level calibration control: registers, per-channel running averages and offset loop
// Assumes: register port and per-row dark averages are synchronous to clk_i
// Function
// - Upper window bound field at bits 14:8, reset 23 hex.
// - Lower window bound field at bits 6:0, reset 1D hex.
// - Control bit 15 disables rapid sweep; averaging keeps running.
// - Writing one to bit 12 starts rapid sweep if enabled, reloads average.
// - Recalculate bit acts only on write of one; always reads zero.
// - Bit 10 set: dark rows 8 to 11 excluded from loop average.
// - Bit 10 clear: every dark row may feed the loop.
// - Bit 9 stops averaging mode changing the value; rapid sweep still works.
// - Bit 8 ramps calibration value by one each frame, same on all channels.
// - Averaging depth is two to the power of bits 7:5, reset 4.
// - Running average = old - old/2^n + new/2^n each frame.
// - Bit 4 forces rapid step of one; otherwise start with larger step.
// - Bit 3 swaps applied calibration values in pairs: green 1 with blue, red with green 2.
// - Bit 2 applies the red value to blue pixels too.
// - Bit 0 selects programmed per-channel values instead of automatic ones.
// - Calibration offsets are 9-bit signed two's complement, bit 8 sign.
`timescale 1ns/1ps
`default_nettype none

module black_level_ctrl #(
	parameter int AVG_W = 10
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [15:0]          reg_wdata_i,
	output logic      [15:0]          reg_rdata_o,
	input  wire logic                 dark_row_valid_i,
	input  wire logic [3:0]           dark_row_idx_i,
	input  wire logic [1:0]           dark_row_ch_i,
	input  wire logic [9:0]           dark_row_avg_i,
	input  wire logic                 frame_end_i,
	input  wire logic [35:0]          manual_cal_i,
	output logic      [35:0]          applied_cal_o,
	output logic      [35:0]          auto_cal_o,
	output logic      [39:0]          running_avg_o,
	output logic                      rapid_active_o
);

	typedef struct packed {
		logic [15:0]                     ctrl;
		logic [6:0]                      win_hi;
		logic [6:0]                      win_lo;
		logic                            recalc_pend;
		logic                            rapid;
		logic [8:0]                      step;
		logic [black_level_pkg::NUM_CH-1:0][AVG_W+7:0] acc;
		logic [black_level_pkg::NUM_CH-1:0][AVG_W+3:0] row_sum;
		logic [black_level_pkg::NUM_CH-1:0][3:0]       row_cnt;
		logic [black_level_pkg::NUM_CH-1:0][8:0]       cal;
		logic [black_level_pkg::NUM_CH-1:0][8:0]       applied;
		logic [15:0]                     rdata;
	} state_type;

	state_type r, r_nxt;

	// Running averages keep a fixed fraction, so a change of depth does not rescale them
	localparam int AVG_FRAC = (1 << (black_level_pkg::AVG_MSB - black_level_pkg::AVG_LSB + 1)) - 1;

	////////////////////////////////////////////////////////////////////////////////
	// Combinational next state

	logic [2:0]                        avg_n;
	logic [black_level_pkg::NUM_CH-1:0][9:0] frame_avg;
	logic [black_level_pkg::NUM_CH-1:0][9:0] run_avg;
	logic [black_level_pkg::NUM_CH-1:0][8:0] src;
	logic                              any_out;
	logic                              row_used;

	always_comb begin
		r_nxt    = r;
		avg_n    = r.ctrl[black_level_pkg::AVG_MSB:black_level_pkg::AVG_LSB];
		any_out  = 1'b0;
		row_used = 1'b0;
		frame_avg = '0;
		run_avg   = '0;
		src       = '0;

		// Register writes
		if (reg_wr_i && reg_addr_i == black_level_pkg::CTRL_ADDR) begin
			r_nxt.ctrl = reg_wdata_i & black_level_pkg::CTRL_WMASK;
			if (reg_wdata_i[black_level_pkg::BIT_RECALC]) begin
				r_nxt.recalc_pend = 1'b1;
			end
		end
		if (reg_wr_i && reg_addr_i == black_level_pkg::WINDOW_ADDR) begin
			r_nxt.win_hi = reg_wdata_i[black_level_pkg::WIN_HI_MSB:black_level_pkg::WIN_HI_LSB];
			r_nxt.win_lo = reg_wdata_i[black_level_pkg::WIN_LO_MSB:black_level_pkg::WIN_LO_LSB];
		end

		// Register reads; recalculate bit always zero
		if (reg_rd_i) begin
			case (reg_addr_i)
				black_level_pkg::CTRL_ADDR:   r_nxt.rdata = r.ctrl;
				black_level_pkg::WINDOW_ADDR: r_nxt.rdata = {1'b0, r.win_hi, 1'b0, r.win_lo};
				default:                      r_nxt.rdata = 16'h0000;
			endcase
		end

		// Dark row accumulation per channel
		if (dark_row_valid_i) begin
			row_used = !(r.ctrl[black_level_pkg::BIT_LIMIT_ROWS]
				&& dark_row_idx_i >= black_level_pkg::LIMIT_ROW_FIRST
				&& dark_row_idx_i <= black_level_pkg::LIMIT_ROW_LAST);
			if (row_used) begin
				r_nxt.row_sum[dark_row_ch_i] = r.row_sum[dark_row_ch_i] + (AVG_W+4)'(dark_row_avg_i);
				r_nxt.row_cnt[dark_row_ch_i] = r.row_cnt[dark_row_ch_i] + 4'h1;
			end
		end

		// Frame update
		if (frame_end_i) begin
			for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
				frame_avg[c] = (r.row_cnt[c] == 4'h0) ? 10'h000
					: 10'((r.row_sum[c]) / (AVG_W+4)'(r.row_cnt[c]));
				if (r.recalc_pend) begin
					r_nxt.acc[c] = (AVG_W+8)'(frame_avg[c]) << AVG_FRAC;
				end else begin
					r_nxt.acc[c] = r.acc[c] - (r.acc[c] >> avg_n)
						+ ((AVG_W+8)'(frame_avg[c]) << (AVG_FRAC - int'(avg_n)));
				end
				run_avg[c] = 10'(r_nxt.acc[c] >> AVG_FRAC);
				r_nxt.row_sum[c] = '0;
				r_nxt.row_cnt[c] = '0;
			end

			for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
				if (run_avg[c] > {3'h0, r.win_hi} || run_avg[c] < {3'h0, r.win_lo}) begin
					any_out = 1'b1;
				end
			end

			if (r.recalc_pend && !r.ctrl[black_level_pkg::BIT_NO_RAPID]) begin
				r_nxt.rapid = 1'b1;
				r_nxt.step  = r.ctrl[black_level_pkg::BIT_STEP_ONE] ? 9'h001
					: black_level_pkg::RAPID_STEP_START;
			end
			r_nxt.recalc_pend = reg_wr_i && reg_addr_i == black_level_pkg::CTRL_ADDR
				&& reg_wdata_i[black_level_pkg::BIT_RECALC];

			if (r.ctrl[black_level_pkg::BIT_SWEEP]) begin
				for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
					r_nxt.cal[c] = r.cal[0] + 9'h001;
				end
			end else if (r.rapid && !r.ctrl[black_level_pkg::BIT_NO_RAPID]) begin
				for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
					r_nxt.cal[c] = step_cal(r.cal[c], run_avg[c], r.step);
				end
				if (r.step > 9'h001) begin
					r_nxt.step = r.step >> 1;
				end else if (!any_out) begin
					r_nxt.rapid = 1'b0;
				end
			end else if (!r.ctrl[black_level_pkg::BIT_FREEZE]) begin
				for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
					r_nxt.cal[c] = step_cal(r.cal[c], run_avg[c], 9'h001);
				end
			end
			// Disabled rapid sweep ends at the next frame, whatever mode runs
			if (r.ctrl[black_level_pkg::BIT_NO_RAPID]) begin
				r_nxt.rapid = 1'b0;
			end
		end

		// Source choice and channel mapping for the applied values
		for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
			src[c] = r.ctrl[black_level_pkg::BIT_MANUAL] ? manual_cal_i[c*9 +: 9] : r.cal[c];
		end
		if (r.ctrl[black_level_pkg::BIT_SWAP]) begin
			r_nxt.applied[black_level_pkg::CH_GREEN1] = src[black_level_pkg::CH_BLUE];
			r_nxt.applied[black_level_pkg::CH_RED]    = src[black_level_pkg::CH_GREEN2];
			r_nxt.applied[black_level_pkg::CH_BLUE]   = src[black_level_pkg::CH_GREEN1];
			r_nxt.applied[black_level_pkg::CH_GREEN2] = src[black_level_pkg::CH_RED];
		end else begin
			r_nxt.applied = src;
		end
		if (r.ctrl[black_level_pkg::BIT_SAME_RB]) begin
			r_nxt.applied[black_level_pkg::CH_BLUE] = r_nxt.applied[black_level_pkg::CH_RED];
		end
		if (r.ctrl[black_level_pkg::BIT_SAME_GREEN]) begin
			r_nxt.applied[black_level_pkg::CH_GREEN2] = r_nxt.applied[black_level_pkg::CH_GREEN1];
		end
		if (r.ctrl[black_level_pkg::BIT_SWEEP] && !r.ctrl[black_level_pkg::BIT_MANUAL]) begin
			for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
				r_nxt.applied[c] = r.cal[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Signed saturating step toward the window

	function automatic logic [8:0] step_cal(input logic [8:0] cur, input logic [9:0] avg,
		input logic [8:0] stp);
		logic signed [10:0] sum;
		sum = 11'sd0;
		step_cal = cur;
		if (avg > {3'h0, r.win_hi}) begin
			sum = $signed({{2{cur[8]}}, cur}) - $signed({2'b00, stp});
		end else if (avg < {3'h0, r.win_lo}) begin
			sum = $signed({{2{cur[8]}}, cur}) + $signed({2'b00, stp});
		end else begin
			sum = $signed({{2{cur[8]}}, cur});
		end
		if (sum > $signed(11'(black_level_pkg::CAL_MAX))) begin
			step_cal = black_level_pkg::CAL_MAX;
		end else if (sum < $signed({{2{1'b1}}, black_level_pkg::CAL_MIN})) begin
			step_cal = black_level_pkg::CAL_MIN;
		end else begin
			step_cal = sum[8:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r        <= '0;
			r.ctrl   <= black_level_pkg::CTRL_RESET;
			r.win_hi <= black_level_pkg::WIN_HI_RESET;
			r.win_lo <= black_level_pkg::WIN_LO_RESET;
		end else begin
			r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		reg_rdata_o    = r.rdata;
		applied_cal_o  = r.applied;
		auto_cal_o     = r.cal;
		rapid_active_o = r.rapid;
		for (int c = 0; c < black_level_pkg::NUM_CH; c++) begin
			running_avg_o[c*10 +: 10] = 10'(r.acc[c] >> AVG_FRAC);
		end
	end

endmodule // black_level_ctrl

`default_nettype wire

// ==== hdl/black_level_pkg.sv ====
// Package: register map, field positions, reset values and limits of the black level loop
// Assumes: included before the control module; no other dependencies
package black_level_pkg;
	localparam logic [7:0]  CTRL_ADDR        = 8'h60;
	localparam logic [7:0]  WINDOW_ADDR      = 8'h5f;
	localparam int          WIN_HI_MSB       = 14;
	localparam int          WIN_HI_LSB       = 8;
	localparam int          WIN_LO_MSB       = 6;
	localparam int          WIN_LO_LSB       = 0;
	localparam logic [6:0]  WIN_HI_RESET     = 7'h23;
	localparam logic [6:0]  WIN_LO_RESET     = 7'h1d;
	localparam int          BIT_NO_RAPID     = 15;
	localparam int          BIT_RECALC       = 12;
	localparam int          BIT_LIMIT_ROWS   = 10;
	localparam int          BIT_FREEZE       = 9;
	localparam int          BIT_SWEEP        = 8;
	localparam int          AVG_MSB          = 7;
	localparam int          AVG_LSB          = 5;
	localparam int          BIT_STEP_ONE     = 4;
	localparam int          BIT_SWAP         = 3;
	localparam int          BIT_SAME_RB      = 2;
	localparam int          BIT_SAME_GREEN   = 1;
	localparam int          BIT_MANUAL       = 0;
	localparam logic [15:0] CTRL_RESET       = 16'h0080;
	localparam logic [15:0] CTRL_WMASK       = 16'h87ff;
	localparam logic [3:0]  LIMIT_ROW_FIRST  = 4'h8;
	localparam logic [3:0]  LIMIT_ROW_LAST   = 4'hb;
	localparam logic [8:0]  RAPID_STEP_START = 9'h020;
	localparam logic [8:0]  CAL_MAX          = 9'h0ff;
	localparam logic [8:0]  CAL_MIN          = 9'h100;
	localparam int          NUM_CH           = 4;
	localparam logic [1:0]  CH_GREEN1        = 2'h0;
	localparam logic [1:0]  CH_BLUE          = 2'h1;
	localparam logic [1:0]  CH_RED           = 2'h2;
	localparam logic [1:0]  CH_GREEN2        = 2'h3;
endpackage

// ==== sim/black_level_ctrl_properties.sv ====
// Checker: port relations of the black level control
// Assumes: bound to black_level_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module black_level_checker #(
	parameter int AVG_W = 10
) (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        frame_end_i,
	input wire logic [35:0] manual_cal_i,
	input wire logic [35:0] applied_cal_o,
	input wire logic        rapid_active_o
);
	logic [15:0] ctl_r;
	logic [15:0] win_r;
	wire logic rd_ctl = reg_rd_i && reg_addr_i == black_level_pkg::CTRL_ADDR;
	wire logic rd_win = reg_rd_i && reg_addr_i == black_level_pkg::WINDOW_ADDR;
	wire logic [35:0] m = manual_cal_i;
	wire logic [35:0] a = applied_cal_o;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctl_r <= black_level_pkg::CTRL_RESET;
			win_r <= {1'b0, black_level_pkg::WIN_HI_RESET, 1'b0, black_level_pkg::WIN_LO_RESET};
		end else if (reg_wr_i && reg_addr_i == black_level_pkg::CTRL_ADDR) begin
			ctl_r <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == black_level_pkg::WINDOW_ADDR) begin
			win_r <= reg_wdata_i & 16'h7f7f;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	ctl_read_a: assert property (rd_ctl |=> reg_rdata_o == ($past(ctl_r) & 16'h87ff))
		else $error("control read back wrong");
	recalc_zero_a: assert property (rd_ctl |=> !reg_rdata_o[12])
		else $error("recalculate bit read as one");
	win_read_a: assert property (rd_win |=> reg_rdata_o == $past(win_r))
		else $error("window read back wrong");
	rapid_off_a: assert property (ctl_r[15] && frame_end_i |-> ##3 !rapid_active_o)
		else $error("rapid sweep ran while disabled");
	sweep_same_a: assert property (ctl_r[8] && frame_end_i |-> ##3 (a[8:0] == a[17:9]
		&& a[8:0] == a[26:18] && a[8:0] == a[35:27]))
		else $error("sweep channels differ");
	manual_a: assert property (frame_end_i && ctl_r[8:0] == 9'h081 |-> ##3 a == m)
		else $error("manual offsets not applied");
	same_rb_a: assert property (frame_end_i && ctl_r[3:2] == 2'h1 && !ctl_r[8]
		|-> ##3 a[17:9] == a[26:18])
		else $error("blue differs from red");
	swap_a: assert property (frame_end_i && ctl_r[8:0] == 9'h089
		|-> ##3 a == {m[26:18], m[35:27], m[8:0], m[17:9]})
		else $error("swapped offsets wrong");
	cover property (frame_end_i && ctl_r[8]);
	cover property (rapid_active_o);
	cover property (rd_win);
endmodule // black_level_checker
bind black_level_ctrl black_level_checker #(.AVG_W(AVG_W)) i_black_level_checker (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .frame_end_i(frame_end_i),
	.manual_cal_i(manual_cal_i), .applied_cal_o(applied_cal_o), .rapid_active_o(rapid_active_o));
`default_nettype wire

// ==== sim/test_black_level_ctrl.sv ====
// Testbench: registers, offset routing, sweep, rapid and averaging
// Assumes: black_level_ctrl with default parameters
`timescale 1ns/1ps
`default_nettype none
module test_black_level_ctrl;
	logic clk_i, rst_n_i, wr, rd, dv, fe, ract;
	logic [7:0] addr;
	logic [15:0] wd, rdat, v;
	logic [3:0] di;
	logic [1:0] dc;
	logic [9:0] da;
	logic [35:0] app, acal, man;
	logic [39:0] ravg;
	logic [8:0] s;
	int n_mismatch, checked, cyc;
	localparam logic [7:0] CA = black_level_pkg::CTRL_ADDR;
	localparam logic [7:0] WA = black_level_pkg::WINDOW_ADDR;
	localparam logic [15:0] RC [4] = '{16'h0081, 16'h0085, 16'h0089, 16'h0083};
	localparam logic [35:0] RE [4] = '{{9'h044, 9'h133, 9'h022, 9'h011}, {9'h044, 9'h133, 9'h133, 9'h011},
		{9'h133, 9'h044, 9'h011, 9'h022}, {9'h011, 9'h133, 9'h022, 9'h011}};
	black_level_ctrl i_black_level_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .dark_row_valid_i(dv), .dark_row_idx_i(di),
		.dark_row_ch_i(dc), .dark_row_avg_i(da), .frame_end_i(fe), .manual_cal_i(man), .applied_cal_o(app),
		.auto_cal_o(acal), .running_avg_o(ravg), .rapid_active_o(ract));
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp_cal(input string n, input logic [35:0] e, input logic [35:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_reg(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_cal(n, {20'h0, e}, {20'h0, g});
	endtask
	task automatic cmp_bit(input string n, input logic e, input logic g);
		cmp_cal(n, {35'h0, e}, {35'h0, g});
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		@(posedge clk_i);
		v = rdat;
	endtask
	task automatic frame(input logic [9:0] lvl);
		for (int c = 0; c < 4; c++) begin
			dv <= 1'b1;
			dc <= 2'(c);
			da <= lvl;
			@(posedge clk_i);
		end
		dv <= 1'b0;
		fe <= 1'b1;
		@(posedge clk_i);
		fe <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'b0;
		{wr, rd, dv, fe} = 4'h0;
		addr = 8'h00;
		wd = 16'h0000;
		dc = 2'h0;
		da = 10'h000;
		di = 4'h0;
		man = {9'h044, 9'h133, 9'h022, 9'h011};
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 4; i++) begin
			wreg(CA, RC[i]);
			frame(10'h040);
			cmp_cal("applied", RE[i], app);
		end
		$display("routing table done");
		rreg(WA);
		cmp_reg("window", 16'h231d, v);
		wreg(WA, 16'hffff);
		rreg(WA);
		cmp_reg("window", 16'h7f7f, v);
		wreg(CA, 16'hffff);
		rreg(CA);
		cmp_reg("control", 16'h87ff, v);
		$display("registers done");
		wreg(CA, 16'h0100);
		frame(10'h040);
		s = app[8:0];
		repeat (3) begin
			frame(10'h040);
			s = s + 9'h001;
			cmp_cal("sweep", {4{s}}, app);
			cmp_cal("sweep auto", {4{s}}, acal);
		end
		$display("sweep done");
		wreg(CA, 16'h9000);
		frame(10'h020);
		cmp_bit("rapid off", 1'b0, ract);
		wreg(CA, 16'h1090);
		frame(10'h040);
		cmp_bit("rapid on", 1'b1, ract);
		cmp_cal("avg reload", {26'h0, 10'h040}, {26'h0, ravg[9:0]});
		wreg(CA, 16'h8000);
		frame(10'h080);
		cmp_cal("avg depth 0", {26'h0, 10'h080}, {26'h0, ravg[9:0]});
		wreg(CA, 16'h8020);
		frame(10'h040);
		cmp_cal("avg depth 1", {26'h0, 10'h060}, {26'h0, ravg[9:0]});
		$display("loop done");
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rreg(CA);
		cmp_reg("control reset", 16'h0080, v);
		cmp_cal("reset applied", 36'h0, app);
		$display("reset done");
		wreg(CA, 16'h8200);
		frame(10'h010);
		cmp_cal("freeze", 36'h0, acal);
		wreg(CA, 16'h8000);
		frame(10'h010);
		cmp_cal("step up", {4{9'h001}}, acal);
		frame(10'h020);
		cmp_cal("in window", {4{9'h001}}, acal);
		frame(10'h040);
		frame(10'h040);
		cmp_cal("step down signed", {4{9'h1ff}}, acal);
		di <= 4'h9;
		wreg(CA, 16'h8400);
		frame(10'h050);
		cmp_cal("rows limited", 36'h0, {26'h0, ravg[9:0]});
		wreg(CA, 16'h8000);
		frame(10'h050);
		cmp_cal("rows all", {26'h0, 10'h050}, {26'h0, ravg[9:0]});
		wreg(CA, 16'h1000);
		frame(10'h050);
		frame(10'h050);
		cmp_cal("rapid large step", {4{9'h1de}}, acal);
		cmp_bit("rapid running", 1'b1, ract);
		$display("loop steps done");
		summarize();
	end
endmodule // test_black_level_ctrl
`default_nettype wire
